// *** shared/dlc_pkg.sv ***
// Constants and types for the terminal-side lead control block.
// Assumes a single 100 MHz system clock; no imports, use dlc_pkg::name.
package dlc_pkg;

   // ----------------------------------------------------------------
   // Configuration encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DLC_IF_V35   = 2'h0,
      DLC_IF_RS449 = 2'h1,
      DLC_IF_X21   = 2'h2,
      DLC_IF_HSSI  = 2'h3
   } dlc_if_type_t;

   // Code value equals the number of half-second steps
   typedef enum logic [2:0] {
      DLC_TGL_NONE = 3'h0,
      DLC_TGL_0P5  = 3'h1,
      DLC_TGL_1P0  = 3'h2,
      DLC_TGL_1P5  = 3'h3,
      DLC_TGL_2P0  = 3'h4
   } dlc_toggle_t;

   typedef enum logic [1:0] {
      DLC_LEAD_ASSERT   = 2'h0,
      DLC_LEAD_DEASSERT = 2'h1,
      DLC_LEAD_AUTO     = 2'h2
   } dlc_lead_mode_t;

   typedef enum logic {
      DLC_TXSRC_DEVICE   = 1'h0,
      DLC_TXSRC_TERMINAL = 1'h1
   } dlc_tx_src_t;

   typedef enum logic {
      DLC_ST_RUN  = 1'h0,
      DLC_ST_HOLD = 1'h1
   } dlc_state_t;

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam dlc_if_type_t DLC_RST_IF_TYPE = DLC_IF_V35;
   localparam dlc_toggle_t DLC_RST_TOGGLE = DLC_TGL_NONE;
   localparam dlc_lead_mode_t DLC_RST_LSD_MODE = DLC_LEAD_AUTO;
   localparam dlc_lead_mode_t DLC_RST_CA_MODE = DLC_LEAD_AUTO;
   localparam dlc_tx_src_t DLC_RST_TX_SRC = DLC_TXSRC_TERMINAL;
   localparam logic DLC_RST_TX_INV = 1'h0;
   localparam logic DLC_RST_RX_INV = 1'h0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned DLC_CLK_HZ = 100_000_000;
   localparam int unsigned DLC_TOGGLE_STEP_MS = 500;
   localparam int unsigned DLC_TOGGLE_STEP_CYCLES = DLC_CLK_HZ / 1000 * DLC_TOGGLE_STEP_MS;

   // Index of each synchronised clock input
   localparam int DLC_CK_DEV = 0;
   localparam int DLC_CK_TERM = 1;
   localparam int DLC_CK_X21X = 2;
   localparam int DLC_CK_RX = 3;
   localparam int DLC_CK_NUM = 4;

endpackage

// *** hw/dlc_lead_control.sv ***
// Terminal-side lead and clock control for an inverse multiplexer port.
// Assumes config inputs and network status are on ref_clk; the clock
// inputs come from other domains and are oversampled by ref_clk.
//
// Operation
// - Four interface types, V.35 after reset
// - Rate change drops presence lead for interval
// - Interval none/0.5/1.0/1.5/2.0 s, default none
// - Port out of service or loopback triggers
// - Toggled lead: detect lead, or HSSI available
// - Tx source select, independent clock inversion
// - X.21 uses S out, X in
// - Detect lead asserted, deasserted or automatic
// - Automatic detect follows clean network signal
// - X.21 indication carries detect; default automatic
// - HSSI automatic: any network signal active
`timescale 1ns/1ps
module dlc_lead_control #(
   parameter int NET_PORTS = 8,
   parameter int unsigned TOGGLE_STEP_CYCLES = dlc_pkg::DLC_TOGGLE_STEP_CYCLES
) (
   input wire logic ref_clk, // System clock, 100 MHz
   input wire logic reset, // Synchronous, active high
   input wire logic [1:0] cfg_if_type, // Interface type select
   input wire logic [2:0] cfg_toggle_sel, // Toggle interval select
   input wire logic cfg_tx_clk_src, // 0 device clock, 1 returned clock
   input wire logic cfg_tx_clk_inv, // Invert transmit clock
   input wire logic cfg_rx_clk_inv, // Invert receive clock
   input wire logic [1:0] cfg_lsd_mode, // Detect lead mode
   input wire logic [1:0] cfg_ca_mode, // HSSI available lead mode
   input wire logic [NET_PORTS-1:0] net_port_in_service, // Per network port in service
   input wire logic [NET_PORTS-1:0] net_signal_active, // Per network port signal present
   input wire logic net_link_up, // Clean signal from network
   input wire logic net_loopback, // Network loopback set
   input wire logic device_clock_ref, // Device transmit clock source
   input wire logic terminal_returned_tx_clock, // Returned clock from terminal
   input wire logic x21_x_clock, // X.21 X clock from terminal
   input wire logic rx_clock_ref, // Receive clock source
   output logic device_tx_clock, // Device transmit clock lead
   output logic x21_s_clock, // X.21 S clock lead
   output logic tx_sample_clock, // Selected, polarised transmit clock
   output logic tx_clock_rise, // One-cycle strobe on its rising edge
   output logic rx_clock, // Polarised receive clock lead
   output logic line_signal_detect_lead, // Detect lead, V.35 and RS-449
   output logic x21_indication_lead, // X.21 indication lead
   output logic hssi_available_lead, // HSSI available lead
   output logic toggle_active // Rate-change interval running
);

   // ----------------------------------------------------------------
   // Configuration capture
   // ----------------------------------------------------------------
   dlc_pkg::dlc_if_type_t if_type_q;
   dlc_pkg::dlc_toggle_t toggle_sel_q;
   dlc_pkg::dlc_lead_mode_t lsd_mode_q;
   dlc_pkg::dlc_lead_mode_t ca_mode_q;
   dlc_pkg::dlc_tx_src_t tx_src_q;
   logic tx_inv_q;
   logic rx_inv_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         if_type_q <= dlc_pkg::DLC_RST_IF_TYPE;
         toggle_sel_q <= dlc_pkg::DLC_RST_TOGGLE;
         lsd_mode_q <= dlc_pkg::DLC_RST_LSD_MODE;
         ca_mode_q <= dlc_pkg::DLC_RST_CA_MODE;
         tx_src_q <= dlc_pkg::DLC_RST_TX_SRC;
         tx_inv_q <= dlc_pkg::DLC_RST_TX_INV;
         rx_inv_q <= dlc_pkg::DLC_RST_RX_INV;
      end else begin
         if_type_q <= dlc_pkg::dlc_if_type_t'(cfg_if_type);
         toggle_sel_q <= dlc_pkg::dlc_toggle_t'(cfg_toggle_sel);
         lsd_mode_q <= dlc_pkg::dlc_lead_mode_t'(cfg_lsd_mode);
         ca_mode_q <= dlc_pkg::dlc_lead_mode_t'(cfg_ca_mode);
         tx_src_q <= dlc_pkg::dlc_tx_src_t'(cfg_tx_clk_src);
         tx_inv_q <= cfg_tx_clk_inv;
         rx_inv_q <= cfg_rx_clk_inv;
      end
   end

   // ----------------------------------------------------------------
   // Rate change detection
   // ----------------------------------------------------------------
   logic [NET_PORTS-1:0] svc_prev_q;
   logic loop_prev_q;
   logic rate_change;
   logic [2:0] steps;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         svc_prev_q <= '0;
         loop_prev_q <= 1'h0;
      end else begin
         svc_prev_q <= net_port_in_service;
         loop_prev_q <= net_loopback;
      end
   end

   // Failure and operator removal both show as in-service falling
   assign rate_change = (|(svc_prev_q & ~net_port_in_service)) | (net_loopback & ~loop_prev_q);

   // Codes above 2.0 s are treated as none rather than a longer hold
   assign steps = (toggle_sel_q > dlc_pkg::DLC_TGL_2P0) ? 3'h0 : toggle_sel_q;

   // ----------------------------------------------------------------
   // Toggle interval timer
   // ----------------------------------------------------------------
   dlc_pkg::dlc_state_t state_q;
   logic [31:0] elapsed_q;
   logic [31:0] target_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_q <= dlc_pkg::DLC_ST_RUN;
         elapsed_q <= 32'h0;
         target_q <= 32'h0;
      end else if (rate_change && steps != 3'h0) begin
         // A change inside a running hold starts it afresh
         state_q <= dlc_pkg::DLC_ST_HOLD;
         elapsed_q <= 32'h0;
         target_q <= 32'(steps) * 32'(TOGGLE_STEP_CYCLES);
      end else begin
         case (state_q)
            dlc_pkg::DLC_ST_RUN: begin
               elapsed_q <= 32'h0;
            end
            dlc_pkg::DLC_ST_HOLD: begin
               if (elapsed_q == target_q - 32'h1) begin
                  state_q <= dlc_pkg::DLC_ST_RUN;
                  elapsed_q <= 32'h0;
               end else begin
                  elapsed_q <= elapsed_q + 32'h1;
               end
            end
            default: begin
               state_q <= dlc_pkg::DLC_ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Signal presence leads
   // ----------------------------------------------------------------
   logic lsd_level;
   logic ca_level;
   logic lsd_q;
   logic ind_q;
   logic ca_q;
   logic hold_q;

   function automatic logic lead_level(input dlc_pkg::dlc_lead_mode_t mode, input logic auto_level);
      case (mode)
         dlc_pkg::DLC_LEAD_ASSERT: lead_level = 1'h1;
         dlc_pkg::DLC_LEAD_DEASSERT: lead_level = 1'h0;
         dlc_pkg::DLC_LEAD_AUTO: lead_level = auto_level;
         default: lead_level = 1'h0;
      endcase
   endfunction

   assign lsd_level = lead_level(lsd_mode_q, net_link_up);
   assign ca_level = lead_level(ca_mode_q, |net_signal_active);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lsd_q <= 1'h0;
         ind_q <= 1'h0;
         ca_q <= 1'h0;
         hold_q <= 1'h0;
      end else begin
         hold_q <= (state_q == dlc_pkg::DLC_ST_HOLD);
         // The hold overrides even a forced assert
         lsd_q <= (if_type_q == dlc_pkg::DLC_IF_V35 || if_type_q == dlc_pkg::DLC_IF_RS449)
                  && lsd_level && state_q == dlc_pkg::DLC_ST_RUN;
         ind_q <= (if_type_q == dlc_pkg::DLC_IF_X21) && lsd_level && state_q == dlc_pkg::DLC_ST_RUN;
         ca_q <= (if_type_q == dlc_pkg::DLC_IF_HSSI) && ca_level && state_q == dlc_pkg::DLC_ST_RUN;
      end
   end

   // ----------------------------------------------------------------
   // Clock input sampling
   // ----------------------------------------------------------------
   logic [dlc_pkg::DLC_CK_NUM-1:0] ck_raw;
   logic [dlc_pkg::DLC_CK_NUM-1:0] ck_s1_q;
   logic [dlc_pkg::DLC_CK_NUM-1:0] ck_s2_q;
   logic [dlc_pkg::DLC_CK_NUM-1:0] ck_s3_q;
   logic [dlc_pkg::DLC_CK_NUM-1:0] ck_q;

   assign ck_raw = {rx_clock_ref, x21_x_clock, terminal_returned_tx_clock, device_clock_ref};

   // A level counts only once two late stages agree, filtering sampling glitches
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ck_s1_q <= '0;
         ck_s2_q <= '0;
         ck_s3_q <= '0;
         ck_q <= '0;
      end else begin
         ck_s1_q <= ck_raw;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         for (int i = 0; i < dlc_pkg::DLC_CK_NUM; i++) begin
            if (ck_s2_q[i] == ck_s3_q[i]) begin
               ck_q[i] <= ck_s3_q[i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock routing and polarity
   // ----------------------------------------------------------------
   logic ret_clk;
   logic tx_sel;
   logic dev_q;
   logic s_q;
   logic txs_q;
   logic rise_q;
   logic rx_q;

   // In X.21 the returned clock arrives on X instead
   assign ret_clk = (if_type_q == dlc_pkg::DLC_IF_X21) ? ck_q[dlc_pkg::DLC_CK_X21X] : ck_q[dlc_pkg::DLC_CK_TERM];
   assign tx_sel = ((tx_src_q == dlc_pkg::DLC_TXSRC_DEVICE) ? ck_q[dlc_pkg::DLC_CK_DEV] : ret_clk) ^ tx_inv_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dev_q <= 1'h0;
         s_q <= 1'h0;
         txs_q <= 1'h0;
         rise_q <= 1'h0;
         rx_q <= 1'h0;
      end else begin
         // Device clock leaves on S in X.21, on its own lead otherwise
         dev_q <= (if_type_q != dlc_pkg::DLC_IF_X21) && (tx_src_q == dlc_pkg::DLC_TXSRC_DEVICE)
                  && ck_q[dlc_pkg::DLC_CK_DEV];
         s_q <= (if_type_q == dlc_pkg::DLC_IF_X21) && (tx_src_q == dlc_pkg::DLC_TXSRC_DEVICE)
                && ck_q[dlc_pkg::DLC_CK_DEV];
         txs_q <= tx_sel;
         rise_q <= tx_sel & ~txs_q;
         rx_q <= ck_q[dlc_pkg::DLC_CK_RX] ^ rx_inv_q;
      end
   end

   assign device_tx_clock = dev_q;
   assign x21_s_clock = s_q;
   assign tx_sample_clock = txs_q;
   assign tx_clock_rise = rise_q;
   assign rx_clock = rx_q;
   assign line_signal_detect_lead = lsd_q;
   assign x21_indication_lead = ind_q;
   assign hssi_available_lead = ca_q;
   assign toggle_active = hold_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_default_if;
      @(posedge ref_clk) $past(reset) && !reset |-> if_type_q == dlc_pkg::DLC_IF_V35 && lsd_mode_q == dlc_pkg::DLC_LEAD_AUTO;
   endproperty
   a_default_if: assert property (p_default_if) else $error("config defaults wrong after reset");

   property p_hold_start;
      @(posedge ref_clk) disable iff (reset) rate_change && steps != 3'h0 |=> state_q == dlc_pkg::DLC_ST_HOLD ##1 toggle_active;
   endproperty
   a_hold_start: assert property (p_hold_start) else $error("rate change did not start hold");

   property p_no_toggle;
      @(posedge ref_clk) disable iff (reset)
         state_q == dlc_pkg::DLC_ST_RUN && toggle_sel_q == dlc_pkg::DLC_TGL_NONE |=> state_q == dlc_pkg::DLC_ST_RUN;
   endproperty
   a_no_toggle: assert property (p_no_toggle) else $error("hold started with interval none");

   property p_duration;
      @(posedge ref_clk) disable iff (reset)
         $fell(state_q == dlc_pkg::DLC_ST_HOLD) |-> $past(elapsed_q) == $past(target_q) - 32'h1
         && $past(target_q) == 32'($past(steps)) * 32'(TOGGLE_STEP_CYCLES);
   endproperty
   a_duration: assert property (p_duration) else $error("hold length wrong");

   property p_loop_trigger;
      @(posedge ref_clk) disable iff (reset) $rose(net_loopback) && steps != 3'h0 |=> state_q == dlc_pkg::DLC_ST_HOLD;
   endproperty
   a_loop_trigger: assert property (p_loop_trigger) else $error("loopback did not trigger hold");

   property p_leads_low;
      @(posedge ref_clk) disable iff (reset)
         state_q == dlc_pkg::DLC_ST_HOLD |=> !line_signal_detect_lead && !x21_indication_lead && !hssi_available_lead;
   endproperty
   a_leads_low: assert property (p_leads_low) else $error("presence lead high during hold");

   property p_rx_inv;
      @(posedge ref_clk) disable iff (reset) ##2 rx_clock == ($past(ck_q[dlc_pkg::DLC_CK_RX]) ^ $past(rx_inv_q));
   endproperty
   a_rx_inv: assert property (p_rx_inv) else $error("rx clock polarity wrong");

   property p_x21_s;
      @(posedge ref_clk) disable iff (reset) if_type_q == dlc_pkg::DLC_IF_X21 |=> !device_tx_clock && !line_signal_detect_lead;
   endproperty
   a_x21_s: assert property (p_x21_s) else $error("non X.21 lead driven in X.21 mode");

   property p_auto_lsd;
      @(posedge ref_clk) disable iff (reset)
         state_q == dlc_pkg::DLC_ST_RUN && lsd_mode_q == dlc_pkg::DLC_LEAD_AUTO && if_type_q == dlc_pkg::DLC_IF_V35
         |=> line_signal_detect_lead == $past(net_link_up);
   endproperty
   a_auto_lsd: assert property (p_auto_lsd) else $error("auto detect lead not following link");

   property p_x21_ind;
      @(posedge ref_clk) disable iff (reset)
         state_q == dlc_pkg::DLC_ST_RUN && lsd_mode_q == dlc_pkg::DLC_LEAD_ASSERT && if_type_q == dlc_pkg::DLC_IF_X21
         |=> x21_indication_lead;
   endproperty
   a_x21_ind: assert property (p_x21_ind) else $error("X.21 indication not asserted");

   property p_hssi_auto;
      @(posedge ref_clk) disable iff (reset)
         state_q == dlc_pkg::DLC_ST_RUN && ca_mode_q == dlc_pkg::DLC_LEAD_AUTO && if_type_q == dlc_pkg::DLC_IF_HSSI
         |=> hssi_available_lead == $past(|net_signal_active);
   endproperty
   a_hssi_auto: assert property (p_hssi_auto) else $error("HSSI available not following signals");

   property p_restart;
      @(posedge ref_clk) disable iff (reset)
         state_q == dlc_pkg::DLC_ST_HOLD && rate_change && steps != 3'h0 |=> elapsed_q == 32'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("hold not restarted");

   c_hold: cover property (@(posedge ref_clk) disable iff (reset) $rose(toggle_active));
   c_restart: cover property (@(posedge ref_clk) disable iff (reset) state_q == dlc_pkg::DLC_ST_HOLD && rate_change);
   c_hssi_hold: cover property (@(posedge ref_clk) disable iff (reset)
      if_type_q == dlc_pkg::DLC_IF_HSSI && $fell(toggle_active));

endmodule

// *** tb/dlc_dte_model.sv ***
// Terminal-side partner: returns the transmit clock to the port.
// Assumes the bench picks running or a still level, and the wiring kind.
`timescale 1ns/1ps
module dlc_dte_model (
   input wire logic run, // Return clock running
   input wire logic lvl, // Level held while stopped
   input wire logic x21, // X.21 wiring in use
   output logic terminal_returned_tx_clock, // Returned clock, non-X.21
   output logic x21_x_clock // Returned clock on X.21 X
);
   // ------------------------------------------------------------
   // Clock generation
   // ------------------------------------------------------------
   logic clk_q = 1'h0;

   // 80 ns link clock; stands still outside traffic
   always begin
      #40;
      clk_q = run ? ~clk_q : lvl;
   end

   // Unused line carries the inverse so a wrong pick shows up
   assign x21_x_clock = x21 ? clk_q : ~clk_q;
   assign terminal_returned_tx_clock = x21 ? ~clk_q : clk_q;
endmodule

// *** tb/tb_dlc_lead_control.sv ***
// Self-checking bench for the terminal lead and clock control block.
// Assumes dlc_pkg is compiled first and the DTE model sits beside it.
`timescale 1ns/1ps
`define DLC_CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb_dlc_lead_control;
   localparam int STEP = 8;
   logic ref_clk, reset, cfg_tx_clk_src, cfg_tx_clk_inv, cfg_rx_clk_inv;
   logic [1:0] cfg_if_type, cfg_lsd_mode, cfg_ca_mode;
   logic [2:0] cfg_toggle_sel;
   logic [7:0] net_port_in_service, net_signal_active;
   logic net_link_up, net_loopback, device_clock_ref, rx_clock_ref, run, lvl;
   logic term_clk, x_clk, device_tx_clock, x21_s_clock, tx_sample_clock, tx_clock_rise;
   logic rx_clock, line_signal_detect_lead, x21_indication_lead, hssi_available_lead, toggle_active;
   int mismatches = 0;
   int n_checks = 0;

   dlc_lead_control #(.NET_PORTS(8), .TOGGLE_STEP_CYCLES(STEP)) u_dut (
      .ref_clk(ref_clk), .reset(reset), .cfg_if_type(cfg_if_type), .cfg_toggle_sel(cfg_toggle_sel),
      .cfg_tx_clk_src(cfg_tx_clk_src), .cfg_tx_clk_inv(cfg_tx_clk_inv), .cfg_rx_clk_inv(cfg_rx_clk_inv),
      .cfg_lsd_mode(cfg_lsd_mode), .cfg_ca_mode(cfg_ca_mode), .net_port_in_service(net_port_in_service),
      .net_signal_active(net_signal_active), .net_link_up(net_link_up), .net_loopback(net_loopback),
      .device_clock_ref(device_clock_ref), .terminal_returned_tx_clock(term_clk), .x21_x_clock(x_clk),
      .rx_clock_ref(rx_clock_ref), .device_tx_clock(device_tx_clock), .x21_s_clock(x21_s_clock),
      .tx_sample_clock(tx_sample_clock), .tx_clock_rise(tx_clock_rise), .rx_clock(rx_clock),
      .line_signal_detect_lead(line_signal_detect_lead), .x21_indication_lead(x21_indication_lead),
      .hssi_available_lead(hssi_available_lead), .toggle_active(toggle_active));

   dlc_dte_model u_dte (.run(run), .lvl(lvl), .x21(cfg_if_type == 2'h2),
      .terminal_returned_tx_clock(term_clk), .x21_x_clock(x_clk));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Counts cycles with the active presence lead low and with the hold flag up
   task automatic count_low(input int n, output int lo, output int ta);
      lo = 0;
      ta = 0;
      repeat (n) begin
         step(1);
         if ((cfg_if_type == 2'h3 ? hssi_available_lead :
              cfg_if_type == 2'h2 ? x21_indication_lead : line_signal_detect_lead) !== 1'h1) lo++;
         if (toggle_active === 1'h1) ta++;
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_leads;
      logic v, c;
      for (int p = 0; p < 2; p++) begin
         net_link_up = (p == 0);
         net_signal_active = (p == 0) ? 8'h00 : 8'h10;
         for (int t = 0; t < 4; t++) begin
            // Mode code 3 is unused and must drive the lead low
            for (int m = 0; m < 4; m++) begin
               cfg_if_type = t[1:0];
               cfg_lsd_mode = m[1:0];
               cfg_ca_mode = m[1:0];
               step(3);
               v = (m == 0) ? 1'h1 : (m == 2) ? net_link_up : 1'h0;
               c = (m == 0) ? 1'h1 : (m == 2) ? |net_signal_active : 1'h0;
               `DLC_CHK("detect", (t < 2) ? v : 1'h0, line_signal_detect_lead)
               `DLC_CHK("indic", (t == 2) ? v : 1'h0, x21_indication_lead)
               `DLC_CHK("avail", (t == 3) ? c : 1'h0, hssi_available_lead)
            end
         end
      end
      $display("test leads done");
   endtask

   task automatic t_intervals;
      int lo, ta;
      cfg_if_type = 2'h0;
      cfg_lsd_mode = 2'h2;
      net_link_up = 1'b1;
      for (int s = 0; s < 6; s++) begin
         cfg_toggle_sel = s[2:0];
         step(3);
         net_loopback = 1'b1;
         count_low(60, lo, ta);
         `DLC_CHK("low cycles", (s < 5) ? s * STEP : 0, lo)
         `DLC_CHK("hold cycles", (s < 5) ? s * STEP : 0, ta)
         net_loopback = 1'b0;
         count_low(10, lo, ta);
         `DLC_CHK("loop clear", 0, lo)
      end
      $display("test intervals done");
   endtask

   task automatic t_ports;
      int a, b, ta;
      cfg_toggle_sel = 3'h2;
      step(3);
      net_port_in_service = 8'hFE;
      count_low(5, a, ta);
      net_port_in_service = 8'hF6;
      count_low(60, b, ta);
      `DLC_CHK("restart low", 5 + 2 * STEP, a + b)
      net_port_in_service = 8'hFF;
      count_low(30, a, ta);
      `DLC_CHK("return low", 0, a)
      cfg_if_type = 2'h3;
      cfg_ca_mode = 2'h2;
      net_signal_active = 8'h01;
      cfg_toggle_sel = 3'h1;
      step(3);
      net_loopback = 1'b1;
      count_low(30, a, ta);
      `DLC_CHK("avail low", STEP, a)
      net_loopback = 1'b0;
      cfg_toggle_sel = 3'h0;
      $display("test ports done");
   endtask

   task automatic t_clocks;
      logic [1:0] t;
      logic d;
      int rs, rd;
      device_clock_ref = 1'b1;
      lvl = 1'b0;
      rx_clock_ref = 1'b1;
      for (int k = 0; k < 8; k++) begin
         t = k[2] ? 2'h2 : 2'h0;
         cfg_if_type = t;
         cfg_tx_clk_src = k[0];
         cfg_tx_clk_inv = k[1];
         cfg_rx_clk_inv = ~k[1];
         step(16);
         d = (cfg_tx_clk_src == 1'b0);
         `DLC_CHK("tx sample", d ^ cfg_tx_clk_inv, tx_sample_clock)
         `DLC_CHK("rx clock", 1'h1 ^ cfg_rx_clk_inv, rx_clock)
         `DLC_CHK("dev clock", d && t != 2'h2, device_tx_clock)
         `DLC_CHK("s clock", d && t == 2'h2, x21_s_clock)
      end
      cfg_if_type = 2'h0;
      cfg_tx_clk_src = 1'b1;
      cfg_tx_clk_inv = 1'b0;
      step(16);
      rs = 0;
      rd = 0;
      run = 1'b1;
      for (int i = 0; i < 100; i++) begin
         d = term_clk;
         step(1);
         // The model stops at the low level once run drops; the last rise reaches the strobe a few cycles later, and the tail catches it
         if (d === 1'b0 && term_clk === 1'b1) rs++;
         if (i == 80) run = 1'b0;
         if (tx_clock_rise === 1'b1) rd++;
      end
      `DLC_CHK("rise count", rs, rd)
      $display("test clocks done");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      cfg_if_type = 2'h0;
      cfg_toggle_sel = 3'h0;
      cfg_tx_clk_src = 1'b1;
      cfg_tx_clk_inv = 1'b0;
      cfg_rx_clk_inv = 1'b0;
      cfg_lsd_mode = 2'h2;
      cfg_ca_mode = 2'h2;
      net_port_in_service = 8'hFF;
      net_signal_active = 8'h00;
      net_link_up = 1'b1;
      net_loopback = 1'b0;
      device_clock_ref = 1'b0;
      rx_clock_ref = 1'b0;
      run = 1'b0;
      lvl = 1'b0;
      step(16);
      reset = 1'b0;
      step(3);
      t_leads();
      t_intervals();
      t_ports();
      t_clocks();
      end_sim();
   end

   // Whole run is about 930 cycles; allow over five times that
   initial begin
      #50000;
      mismatches++;
      end_sim();
   end
endmodule
